// file: verif/kss_keymatrix.sv
// Purpose: one-key matrix model. Assumes: column pull-ups. Notes: no bounce.
`timescale 1ns/1ps
`default_nettype none
module kss_keymatrix (input wire logic i_on, input wire logic [7:0] i_row,
  input wire logic [5:0] i_key, output logic [7:0] o_col);
  assign o_col = (i_on && !i_row[i_key[5:3]]) ?
    8'(~(8'h01 << i_key[2:0])) : 8'hFF;
endmodule // kss_keymatrix
`default_nettype wire

// file: verif/kss_scanner_chk.sv
// Purpose: scanner port checks. Assumes: one clock. Notes: bound below.
`timescale 1ns/1ps
`default_nettype none
module kss_scanner_chk (input wire logic i_clk, i_rst_b, i_scan_restart,
  input wire logic o_key_valid, input wire logic [7:0] i_col, o_row,
  input wire logic [5:0] o_key_code);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  sequence rot_s; $changed(o_row) && !$past(i_scan_restart); endsequence
  one_low_a: assert property ($countones(~o_row) == 1)
    else $error("row pattern broken");
  row_dir_a: assert property (rot_s |->
    $past(o_row) == {o_row[0], o_row[7:1]}) else $error("bad rotation");
  step_gap_a: assert property (rot_s |->
    $past(o_row, 2) == $past(o_row)) else $error("step too short");
  row_hold_a: assert property (!(&i_col) && !i_scan_restart |=>
    $stable(o_row)) else $error("row moved while held");
  restart_a: assert property (i_scan_restart |=> o_row == 8'hFE &&
    o_key_code == 6'h3F && !o_key_valid) else $error("restart ignored");
  idle_code_a: assert property (&i_col && !i_scan_restart |=>
    o_key_code == 6'h3F && !o_key_valid) else $error("idle code wrong");
  key_seen_a: assert property (!(&i_col) && !i_scan_restart &&
    (i_col != 8'h7F || o_row[7]) |=> o_key_valid) else $error("no valid");
  enc_row_a: assert property (o_key_valid |->
    !o_row[o_key_code[5:3]] && o_key_code != 6'h3F) else $error("bad row");
endmodule // kss_scanner_chk
bind kss_scanner kss_scanner_chk u_chk (.*);
`default_nettype wire

// file: verif/kss_scanner_tb.sv
// Purpose: scanner bench. Assumes: 40 MHz clock. Notes: scan step of 4.
`timescale 1ns/1ps
`default_nettype none
module kss_scanner_tb;
  logic i_clk = 1, i_rst_b = 0, i_scan_restart = 0, on = 1, o_key_valid;
  logic [5:0] key = 6'h05, o_key_code;
  logic [7:0] i_col, o_row;
  int n_errors = 0, n_tests = 0;
  wire [7:0] seen = {1'b0, o_key_valid, o_key_code};
  initial forever #12.5 i_clk = ~i_clk;
  kss_scanner #(.STEP_CYC(4)) dut (.*);
  kss_keymatrix mtx (.i_on(on), .i_row(o_row), .i_key(key), .o_col(i_col));
  task automatic chk(input logic [7:0] g, e);
    n_tests++;
    n_errors += int'(g !== e);
    if (g !== e) $display("wrong value at %0t: %h not %h", $time, g, e);
  endtask
  task automatic wrap_up(input int extra);
    n_errors += extra;
    if (n_errors == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // On its first call restart lands while a key is held on the first row; on the second no key is held
  task automatic t_restart;
    for (int n = 0; n < 8 && !on && o_row == 8'hFE; n++) #25;
    i_scan_restart = 1;
    #25;
    i_scan_restart = 0;
    chk(o_row, 8'hFE);
    chk(seen, 8'h3F);
  endtask
  // Top corner key shares the idle code, so it must stay invalid
  task automatic t_keys;
    for (int k = 0; k < 64; k++) begin
      {key, on} = {6'(k), 1'b1};
      for (int n = 0; n < 40 && o_row[k / 8]; n++) #25;
      #25;
      chk(seen, (k == 63) ? 8'h3F : 8'(64 + k));
      on = 0;
      #25;
      chk(seen, 8'h3F);
    end
  endtask
  initial begin
    #52;
    i_rst_b = 1;
    t_restart();
    t_keys();
    t_restart();
    wrap_up(0);
  end
  initial #200000 wrap_up(1);
endmodule // kss_scanner_tb
`default_nettype wire

// file: verilog/kss_pkg.sv
// Purpose: Shared constants for the key matrix scanner and encoder.
// Assumes: One 40 MHz clock; the scan step comes from a divider enable.
// Notes:   Only the scanner module uses these; kept apart for the bench.
package kss_pkg;

  localparam int unsigned KSS_ROWS_DEF     = 8;
  localparam int unsigned KSS_COLS_DEF     = 8;
  localparam int unsigned KSS_ROWS_MAX     = 8;
  localparam int unsigned KSS_COLS_MAX     = 8;

  // Clock rate and scan step time
  localparam longint unsigned KSS_CLK_HZ   = 64'd40000000;
  localparam longint unsigned KSS_STEP_NS  = 64'd1000;
  localparam longint unsigned KSS_NS_PER_S = 64'd1000000000;
  // Longest step time, so round down; never below one cycle
  localparam int unsigned KSS_STEP_RAW     =
    int'((KSS_STEP_NS * KSS_CLK_HZ) / KSS_NS_PER_S);
  localparam int unsigned KSS_STEP_CYC     =
    (KSS_STEP_RAW < 1) ? 1 : KSS_STEP_RAW;

  // Position of the single zero in the row pattern after reset
  localparam int unsigned KSS_ZERO_POS     = 0;

  // Encoded word layout: row index above column index
  localparam int unsigned KSS_COL_LSB      = 0;

endpackage : kss_pkg

// file: verilog/kss_scanner.sv
// Purpose: Scan an 8 x 8 key matrix and present a six-bit key code.
// Assumes: Column inputs carry pad pull-ups and are synchronous to i_clk.
// Notes:   Debounce is left to the host; code follows the raw matrix.
//          A stuck key freezes the scan on its row until it lets go;
//          the host sees a steady code and can flag it after a timeout.
//          Ghost presses on several columns resolve to the lowest column.
//
// Contract
// R1: The matrix has eight row outputs and eight column inputs.
// R2: After init the row pattern is all ones except a single zero.
// R3: Each stage of the row pattern drives one row line directly.
// R4: On each enabled step the pattern rotates so one row is low in turn.
// R5: Column lines are pulled up and read high unless a key pulls them low.
// R6: The AND of all columns is high for no key and low for a pressed key.
// R7: The column AND is the shift enable, so scanning holds while pressed.
// R8: A row encoder and a column encoder are joined into the key code.
// R9: The key code is six bits with one value reserved for no key.
// R10: On a press scanning stops and the key code appears at once.
// R11: An optional valid output lets all sixty-four codes name keys.
// R12: Debounce is done either here or in the host; here it is the host.
// R13: The host watches the code for changes and reads the key from it.
// R14: With no key the code is a fixed idle value no real key produces.
// R15: A synchronous restart reloads the single-zero row pattern.
`timescale 1ns/1ps
`default_nettype none

module kss_scanner
  import kss_pkg::*;
#(
  parameter int unsigned ROWS       = kss_pkg::KSS_ROWS_DEF,
  parameter int unsigned COLS       = kss_pkg::KSS_COLS_DEF,
  parameter int unsigned STEP_CYC   = kss_pkg::KSS_STEP_CYC,
  parameter bit          FULL_CODES = 1'b0,
  localparam int unsigned ROW_W     = (ROWS > 1) ? $clog2(ROWS) : 1,
  localparam int unsigned COL_W     = (COLS > 1) ? $clog2(COLS) : 1,
  localparam int unsigned CODE_W    = ROW_W + COL_W
) (
  input  wire logic              i_clk,
  input  wire logic              i_rst_b,
  input  wire logic              i_scan_restart,
  input  wire logic [COLS-1:0]   i_col,
  output logic      [ROWS-1:0]   o_row,
  output logic      [CODE_W-1:0] o_key_code,
  output logic                   o_key_valid
);

  import kss_pkg::*;

  localparam int unsigned DIV_W = (STEP_CYC > 1) ? $clog2(STEP_CYC) : 1;
  localparam int unsigned LINES_MAX =
    (KSS_ROWS_MAX > KSS_COLS_MAX) ? KSS_ROWS_MAX : KSS_COLS_MAX;
  localparam logic [CODE_W-1:0] IDLE_CODE = {CODE_W{1'b1}};
  localparam logic [DIV_W-1:0]  DIV_LAST  = DIV_W'(STEP_CYC - 1);
  localparam logic [ROWS-1:0]   ROW_INIT  =
    ~(ROWS'(1) << KSS_ZERO_POS);

  initial begin
    if (ROWS < 2 || ROWS > KSS_ROWS_MAX || (ROWS & (ROWS - 1)) != 0) begin
      $error("kss_scanner: ROWS must be a power of two from 2 to 8");
    end
    if (COLS < 2 || COLS > KSS_COLS_MAX || (COLS & (COLS - 1)) != 0) begin
      $error("kss_scanner: COLS must be a power of two from 2 to 8");
    end
    if (STEP_CYC < 1) begin
      $error("kss_scanner: STEP_CYC must be at least one");
    end
    if (KSS_ZERO_POS >= ROWS) begin
      $error("kss_scanner: zero position outside the row pattern");
    end
  end

  typedef struct packed {
    logic [ROWS-1:0]   row;
    logic [DIV_W-1:0]  div;
    logic [CODE_W-1:0] code;
    logic              valid;
  } kss_state_s;

  kss_state_s state_ff;
  kss_state_s nxt_state;

  logic [ROWS-1:0]   row_sel;
  logic [COLS-1:0]   col_low;
  logic [ROWS-1:0]   row_before;
  logic [COLS-1:0]   col_before;
  logic [ROWS-1:0]   row_first;
  logic [COLS-1:0]   col_first;
  logic [ROWS-1:0]   row_rot;
  logic [ROW_W-1:0]  row_idx;
  logic [COL_W-1:0]  col_idx;
  logic [CODE_W-1:0] raw_code;
  logic              all_high;
  logic              step;
  logic              hit;

  assign row_before[0] = 1'b0;
  assign col_before[0] = 1'b0;

  // Priority chains keep the lowest active line when several are seen,
  // so a ghost press still yields one legal code
  for (genvar g = 0; g < LINES_MAX; g++) begin : g_line
    if (g < ROWS) begin : g_row
      assign row_sel[g]   = ~state_ff.row[g];
      assign row_first[g] = row_sel[g] & ~row_before[g];
      assign row_rot[g]   = state_ff.row[(g + ROWS - 1) % ROWS]; // R4
      if (g + 1 < ROWS) begin : g_next
        assign row_before[g+1] = row_before[g] | row_sel[g];
      end
    end
    if (g < COLS) begin : g_col
      assign col_low[g]   = ~i_col[g];                      // R5
      assign col_first[g] = col_low[g] & ~col_before[g];
      if (g + 1 < COLS) begin : g_next
        assign col_before[g+1] = col_before[g] | col_low[g];
      end
    end
  end

  // One-hot to index: bit b gathers every line whose number has bit b set
  for (genvar b = 0; b < ROW_W; b++) begin : g_row_bit
    logic [ROWS-1:0] pick;
    for (genvar g = 0; g < ROWS; g++) begin : g_pick
      assign pick[g] = (((g >> b) % 2) == 1) ? row_first[g] : 1'b0;
    end
    assign row_idx[b] = |pick;                              // R8
  end
  for (genvar b = 0; b < COL_W; b++) begin : g_col_bit
    logic [COLS-1:0] pick;
    for (genvar g = 0; g < COLS; g++) begin : g_pick
      assign pick[g] = (((g >> b) % 2) == 1) ? col_first[g] : 1'b0;
    end
    assign col_idx[b] = |pick;                              // R8
  end

  assign all_high = &i_col;                                 // R6
  assign step     = (state_ff.div == DIV_LAST);
  assign raw_code = {row_idx, col_idx};                     // R8 R9
  // Without a valid line the last position aliases idle, so it is dropped
  assign hit      = !all_high &&
                    (FULL_CODES || (raw_code != IDLE_CODE)); // R11 R14

  always_comb begin
    nxt_state       = state_ff;
    nxt_state.div   = step ? '0 : state_ff.div + DIV_W'(1);
    // Divider runs on while frozen, so the first step after release
    // may come early; the hold itself is exact
    if (step && all_high) begin                             // R7
      nxt_state.row = row_rot;                              // R4
    end
    // Raw code goes straight out; the host filters contact bounce
    nxt_state.code  = hit ? raw_code : IDLE_CODE;           // R10 R12 R14
    nxt_state.valid = hit;                                  // R11

    if (i_scan_restart) begin
      nxt_state.row   = ROW_INIT;                           // R15
      nxt_state.div   = '0;
      nxt_state.code  = IDLE_CODE;
      nxt_state.valid = 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_ff.row   <= ROW_INIT;                           // R2
      state_ff.div   <= '0;
      state_ff.code  <= IDLE_CODE;
      state_ff.valid <= 1'b0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign o_row       = state_ff.row;                        // R1 R3
  assign o_key_code  = state_ff.code;                       // R13
  assign o_key_valid = state_ff.valid;

endmodule : kss_scanner

`default_nettype wire
